// ==== aqg_gen.sv ====
// Quadrature pulse-train generator with event sequencer and parameter queue.
// Assumes the host drives control bits from another domain, queue writes on core_clk_i.
`timescale 1ns/10ps
module aqg_gen #(
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // Host control bits, asynchronous.
  input  wire logic              load_i,
  input  wire logic              dir_i,
  // Parameter queue write port.
  input  wire logic              param_valid_i,
  input  wire logic [31:0]       param_data_i,
  output logic                   param_ready_o,
  // Pulse outputs and status.
  output aqg_pkg::aqg_quad_t     quad_o,
  output logic [1:0]             event_tag_o,
  output logic                   running_o
);
  localparam int AW = $clog2(DEPTH);
  logic [1:0]  ld_s_r, dir_s_r;
  logic        ld_d_r;
  logic [31:0] fifo_r [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic        fifo_empty, fifo_full, pop;
  aqg_pkg::aqg_seq_t seq_r;
  logic [31:0] ival_cnt_r, ival_cmp_r, edge_cnt_r, edge_cmp_r, idx_cnt_r, idx_hi_r, idx_lo_r;
  logic        halt_r, fin_force_r, stop_r, idx_r;
  logic        ival_clr_r, edge_tick, fin, run;
  logic [1:0]  q_r;

  // Two-flop synchronisers for host control bits.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_s_r  <= 2'h0;
      dir_s_r <= 2'h0;
      ld_d_r  <= 1'b0;
    end else begin
      ld_s_r  <= {ld_s_r[0], load_i};
      dir_s_r <= {dir_s_r[0], dir_i};
      ld_d_r  <= ld_s_r[1];
    end
  end

  // Parameter queue, popped one word per sequencer load step (edge, interval, index high, index low).
  assign fifo_empty = (wp_r == rp_r);
  assign fifo_full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign pop = !fifo_empty && (seq_r inside {aqg_pkg::SQ_EDGE, aqg_pkg::SQ_IVAL, aqg_pkg::SQ_IHI, aqg_pkg::SQ_ILO});
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      param_ready_o <= 1'b0;
    end else begin
      if (param_valid_i && param_ready_o) begin
        fifo_r[wp_r[AW-1:0]] <= param_data_i;
        wp_r <= wp_r + 1'b1;
      end
      if (pop) rp_r <= rp_r + 1'b1;
      param_ready_o <= !fifo_full && !(param_valid_i && param_ready_o &&
                       (wp_r[AW-1:0] + 1'b1 == rp_r[AW-1:0]) && !pop);
    end
  end

  // Event sequencer: load program, stalling on an empty queue.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_r       <= aqg_pkg::SQ_IDLE;
      halt_r      <= 1'b0;
      fin_force_r <= 1'b0;
      edge_cmp_r  <= aqg_pkg::ONES_VAL;
      ival_cmp_r  <= aqg_pkg::ONES_VAL;
      idx_hi_r    <= aqg_pkg::ONES_VAL;
      idx_lo_r    <= aqg_pkg::ONES_VAL;
      ival_clr_r  <= 1'b0;
      event_tag_o <= aqg_pkg::TAG_NONE;
    end else begin
      ival_clr_r <= 1'b0;
      // The done tag is raised in the cycle the stop latch sets, so it always follows the load tag.
      if (fin && !halt_r && !stop_r) event_tag_o <= aqg_pkg::TAG_DONE;
      unique case (seq_r)
        aqg_pkg::SQ_IDLE: begin
          if (ld_s_r[1] && !ld_d_r) begin
            halt_r      <= 1'b1;
            fin_force_r <= 1'b1;
            seq_r       <= aqg_pkg::SQ_HALT;
          end
        end
        aqg_pkg::SQ_HALT: begin
          edge_cmp_r  <= aqg_pkg::ONES_VAL;
          fin_force_r <= 1'b0;
          seq_r       <= aqg_pkg::SQ_EDGE;
        end
        aqg_pkg::SQ_EDGE: if (pop) begin
          edge_cmp_r <= fifo_r[rp_r[AW-1:0]];
          seq_r      <= aqg_pkg::SQ_IVAL;
        end
        aqg_pkg::SQ_IVAL: if (pop) begin
          ival_cmp_r <= fifo_r[rp_r[AW-1:0]];
          seq_r      <= aqg_pkg::SQ_IHI;
        end
        aqg_pkg::SQ_IHI: if (pop) begin
          idx_hi_r   <= fifo_r[rp_r[AW-1:0]];
          ival_clr_r <= 1'b1;
          seq_r      <= aqg_pkg::SQ_ILO;
        end
        aqg_pkg::SQ_ILO: if (pop) begin
          idx_lo_r    <= fifo_r[rp_r[AW-1:0]];
          event_tag_o <= aqg_pkg::TAG_LOAD;
          halt_r      <= 1'b0;
          seq_r       <= aqg_pkg::SQ_IDLE;
        end
      endcase
    end
  end

  // Run gate and finished detect; a zero edge count matches the cleared counter at once.
  assign run = !(stop_r || halt_r);
  assign fin = !fin_force_r && (edge_cnt_r == edge_cmp_r);
  // No tick in the finishing cycle, so a one-clock interval cannot send an extra edge.
  assign edge_tick = run && !fin && (ival_cnt_r == aqg_pkg::TICK_CMP);

  // Stop latch: set on finished level, forced clear while halt is requested.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_r <= 1'b1;
    end else begin
      // A finished level seen once halt drops latches stop, which covers a zero edge count.
      if (halt_r) stop_r <= 1'b0;
      else if (fin) stop_r <= 1'b1;
    end
  end

  // Interval counter producing edge ticks.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) ival_cnt_r <= aqg_pkg::ZERO_VAL;
    else if (ival_clr_r) ival_cnt_r <= aqg_pkg::ZERO_VAL;
    else if (run) begin
      if (ival_cnt_r == ival_cmp_r) ival_cnt_r <= aqg_pkg::ZERO_VAL;
      else ival_cnt_r <= ival_cnt_r + 32'h1;
    end
  end

  // Edge and index counters, cleared when the train finishes.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_cnt_r <= aqg_pkg::ZERO_VAL;
      idx_cnt_r  <= aqg_pkg::ZERO_VAL;
      idx_r      <= 1'b0;
    end else if (fin && !fin_force_r && edge_cmp_r != aqg_pkg::ZERO_VAL && edge_cnt_r != aqg_pkg::ZERO_VAL) begin
      edge_cnt_r <= aqg_pkg::ZERO_VAL;
      idx_cnt_r  <= aqg_pkg::ZERO_VAL;
      idx_r      <= 1'b0;
    end else if (edge_tick) begin
      edge_cnt_r <= edge_cnt_r + 32'h1;
      idx_cnt_r  <= idx_cnt_r + 32'h1;
      if (idx_cnt_r + 32'h1 == idx_hi_r) idx_r <= 1'b1;
      else if (idx_cnt_r + 32'h1 == idx_lo_r) idx_r <= 1'b0;
    end
  end

  // Quadrature state: gray sequence 00,10,11,01 forward as {a,b}.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) q_r <= aqg_pkg::QUAD_RST;
    else if (edge_tick) begin
      if (dir_s_r[1]) q_r <= {~q_r[0], q_r[1]};
      else q_r <= {q_r[0], ~q_r[1]};
    end
  end

  // Registered outputs.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_o    <= '0;
      running_o <= 1'b0;
    end else begin
      quad_o    <= '{a: q_r[1], b: q_r[0], idx: idx_r};
      running_o <= run && !fin;
    end
  end
endmodule

// ==== aqg_gen_assertions.sv ====
// Port checker for the quadrature pulse-train generator.
// Assumes one clock domain; the bind sits at the foot of this file.
`timescale 1ns/10ps
module aqg_gen_assertions #(
  parameter int unsigned DEPTH = 4
) (
  // Clock, reset and host bits.
  input wire logic               core_clk_i,
  input wire logic               nrst_i,
  input wire logic               load_i,
  input wire logic               dir_i,
  // Pulse outputs and status.
  input wire aqg_pkg::aqg_quad_t quad_o,
  input wire logic [1:0]         event_tag_o,
  input wire logic               running_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_ONE_LINE: assert property (!($changed(quad_o.a) && $changed(quad_o.b)))
    else $error("A and B moved together");
  AST_HOLD: assert property ((!running_o) [*4] |-> $stable(quad_o.a) && $stable(quad_o.b))
    else $error("pulse moved while halted");
  AST_FWD: assert property (dir_i && $past(dir_i, 4) && $changed({quad_o.a, quad_o.b})
    |-> quad_o.a != $past(quad_o.b) && quad_o.b == $past(quad_o.a)) else $error("bad forward step");
  AST_REV: assert property (!dir_i && !$past(dir_i, 4) && $changed({quad_o.a, quad_o.b})
    |-> quad_o.a == $past(quad_o.b) && quad_o.b != $past(quad_o.a)) else $error("bad reverse step");
  AST_LOAD_TAG: assert property ($rose(load_i) |-> ##[3:20] event_tag_o == aqg_pkg::TAG_LOAD)
    else $error("no load tag");
  AST_START: assert property ($rose(running_o) |-> event_tag_o == aqg_pkg::TAG_LOAD)
    else $error("run began before load tag");
  AST_IDLE: assert property (event_tag_o == aqg_pkg::TAG_NONE |-> !running_o)
    else $error("running before any load");
  AST_TAG_CODE: assert property (event_tag_o != 2'h3)
    else $error("unknown tag code");
endmodule
bind aqg_gen aqg_gen_assertions #(.DEPTH(DEPTH)) u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .load_i(load_i), .dir_i(dir_i), .quad_o(quad_o), .event_tag_o(event_tag_o), .running_o(running_o));

// ==== aqg_pkg.sv ====
// Constants, carriers and state codes for the quadrature pulse-train generator.
// Assumes one 200 MHz logic clock and a host that pushes words into the parameter queue.
package aqg_pkg;
  localparam int unsigned CNT_W = 32;
  localparam logic [31:0] ZERO_VAL = 32'h0000_0000;
  localparam logic [31:0] ONES_VAL = 32'hFFFF_FFFF;
  localparam logic [31:0] TICK_CMP = 32'h0000_0000;
  localparam logic [1:0]  TAG_NONE = 2'h0;
  localparam logic [1:0]  TAG_LOAD = 2'h1;
  localparam logic [1:0]  TAG_DONE = 2'h2;
  localparam logic [1:0]  QUAD_RST = 2'h0;
  typedef enum logic [5:0] {
    SQ_IDLE = 6'h01,
    SQ_HALT = 6'h02,
    SQ_EDGE = 6'h04,
    SQ_IVAL = 6'h08,
    SQ_IHI  = 6'h10,
    SQ_ILO  = 6'h20
  } aqg_seq_t;
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } aqg_quad_t;
endpackage

// ==== aqg_rx_model.sv ====
// Downstream receiver model: counts A/B edges and notes where the index moves.
// Assumes the pulse lines change only on core_clk_i edges.
`timescale 1ns/10ps
module aqg_rx_model (
  // Clock and count clear.
  input wire logic               core_clk_i,
  input wire logic               clr_i,
  // Pulse lines and results.
  input wire aqg_pkg::aqg_quad_t quad_i,
  output int                     edges_o,
  output int                     gap_o,
  output int                     hi_o,
  output int                     lo_o
);
  aqg_pkg::aqg_quad_t prv;
  int                 run, e;
  // A double change counts twice, so it shows up as a count error.
  always @(posedge core_clk_i) begin
    e = edges_o + int'(quad_i.a ^ prv.a) + int'(quad_i.b ^ prv.b);
    run <= (e != edges_o) ? 1 : run + 1;
    if (e != edges_o) gap_o <= run;
    // A clear forgets the index marks of the previous train.
    if (clr_i) begin
      hi_o <= -1;
      lo_o <= -1;
    end else begin
      if (quad_i.idx && !prv.idx) hi_o <= e;
      if (!quad_i.idx && prv.idx) lo_o <= e;
    end
    edges_o <= clr_i ? 0 : e;
    prv <= quad_i;
  end
endmodule

// ==== tb_aqg_gen.sv ====
// Bench: host words and load go in, a step model predicts the pulses.
// Assumes package, generator, checker and receiver model compile first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_aqg_gen;
  logic core_clk_i, nrst_i, load_i, dir_i, param_valid_i, param_ready_o, running_o, clr;
  logic [31:0] param_data_i, rng;
  logic [1:0] event_tag_o;
  aqg_pkg::aqg_quad_t quad_o;
  int fail_count, n_compared, st, ed, gp, hi, lo;
  logic [1:0] seq[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  aqg_gen #(.DEPTH(4)) u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .load_i(load_i), .dir_i(dir_i),
    .param_valid_i(param_valid_i), .param_data_i(param_data_i), .param_ready_o(param_ready_o),
    .quad_o(quad_o), .event_tag_o(event_tag_o), .running_o(running_o));
  aqg_rx_model u_rx (.core_clk_i(core_clk_i), .clr_i(clr), .quad_i(quad_o), .edges_o(ed), .gap_o(gp),
    .hi_o(hi), .lo_o(lo));
  // Free-running 200 MHz clock.
  initial begin core_clk_i = 0; forever #2.5 core_clk_i = ~core_clk_i; end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic cyc(int n); repeat (n) @(posedge core_clk_i); #1; endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait until the tag equals t; running out ends the run.
  task automatic wait_tag(logic [1:0] t);
    int k;
    for (k = 0; k < 3000 && event_tag_o !== t; k++) cyc(1);
    if (k == 3000) begin fail_count++; stop_test(); end
  endtask
  // One whole train: push four words, load, wait for the end, compare.
  task automatic train(logic [31:0] n, iv, ih, il, logic d);
    logic [31:0] w[4];
    int k, j;
    w = '{n, iv, ih, il};
    dir_i = d;
    clr = 1;
    cyc(1);
    clr = 0;
    param_valid_i = 1;
    for (k = 0; k < 4; k++) begin
      param_data_i = w[k];
      for (j = 0; j < 50 && param_ready_o !== 1'b1; j++) cyc(1);
      if (j == 50) begin fail_count++; stop_test(); end
      cyc(1);
    end
    param_valid_i = 0;
    cyc(1);
    `CHK("ready", 1'b0, param_ready_o)
    load_i = 1;
    wait_tag(aqg_pkg::TAG_LOAD);
    wait_tag(aqg_pkg::TAG_DONE);
    cyc(4);
    load_i = 0;
    st = (st + (d ? n : 4 - n % 4)) % 4;
    `CHK("edges", n, ed)
    `CHK("ab", seq[st], {quad_o.a, quad_o.b})
    `CHK("idx", 1'b0, quad_o.idx)
    `CHK("hi", ih, hi)
    `CHK("lo", il, lo)
    `CHK("run", 1'b0, running_o)
    if (n > 1) `CHK("gap", iv + 1, gp)
    $display("train of %0d edges done", n);
  endtask
  // Reset, fixed trains, then random ones.
  initial begin
    {load_i, dir_i, param_valid_i, clr, nrst_i} = 5'h0;
    param_data_i = 32'h0;
    st = 0;
    rng = 32'h1D;
    cyc(5);
    nrst_i = 1;
    cyc(2);
    `CHK("rst", 7'h01, {quad_o, event_tag_o, running_o, param_ready_o})
    train(6, 3, 2, 4, 1);
    train(0, 2, '1, '1, 1);
    train(5, 0, 1, 3, 0);
    repeat (3) begin
      rng = xs(rng);
      train(rng % 12 + 1, rng % 8, '1, '1, rng[9]);
    end
    stop_test();
  end
endmodule
